// file: bench/txi_cpu_model.sv
// Core sequencer model facing the interrupt controller.
// Assumes clk_sys and a synchronous active-high rst from the bench.
module txi_cpu_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Bench control
	input wire logic abortable,
	input wire logic ret_req,
	// Controller side
	output logic cpu_no_write,
	output logic cpu_instr_done,
	output logic cpu_iret
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_q;
	// Slow mode: a written instruction cannot be cut, it ends every fourth cycle
	assign cpu_no_write = abortable;
	assign cpu_instr_done = !abortable && cnt_q == 2'h3;
	always_ff @(posedge clk_sys)
	begin
		cnt_q <= rst ? 2'h0 : cnt_q + 2'h1;
		cpu_iret <= !rst && ret_req;
	end
endmodule : txi_cpu_model

// file: bench/txi_top_tb_top.sv
// Self-checking bench of the interrupt controller: registers, edges, arbitration, timing.
// Assumes txi_top, the core sequencer model and one 125 MHz clock.
module txi_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} txi_row_s;
	logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, nmi_pin, wdg_end_of_count;
	logic [7:0] avs_address, ext_pin, isr_vector, r;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] periph_trig;
	logic cpu_no_write, cpu_instr_done, cpu_iret, cpu_ei, cpu_di, cpu_abort, isr_start;
	logic isr_top, top_in_service, dma_block, global_counter_enable, abortable, ret_req;
	int bad_count, checked, gap, lat;
	txi_row_s rows[14] = '{'{8'he6, 1'b0, 8'h00, 8'h87}, '{8'hf2, 1'b0, 8'h00, 8'h00},
		'{8'hf3, 1'b0, 8'h00, 8'h00}, '{8'hf4, 1'b0, 8'h00, 8'h00}, '{8'hf5, 1'b0, 8'h00, 8'hff},
		'{8'hf6, 1'b0, 8'h00, 8'h04}, '{8'hf7, 1'b0, 8'h00, 8'h00}, '{8'hfa, 1'b0, 8'h00, 8'h00},
		'{8'h20, 1'b0, 8'h00, 8'h00}, '{8'h20, 1'b1, 8'hff, 8'h00}, '{8'hf2, 1'b1, 8'ha5, 8'ha5},
		'{8'he6, 1'b1, 8'h0f, 8'h0f}, '{8'he6, 1'b1, 8'h87, 8'h87}, '{8'hf2, 1'b1, 8'h00, 8'h00}};

	txi_top i_txi_top (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .nmi_pin(nmi_pin), .wdg_end_of_count(wdg_end_of_count),
		.ext_pin(ext_pin), .periph_trig(periph_trig), .periph_level(12'h03a),
		.periph_vector(28'h000002a), .cpu_no_write(cpu_no_write), .cpu_instr_done(cpu_instr_done),
		.cpu_iret(cpu_iret), .cpu_ei(cpu_ei), .cpu_di(cpu_di), .cpu_abort(cpu_abort),
		.isr_start(isr_start), .isr_vector(isr_vector), .isr_top(isr_top),
		.top_in_service(top_in_service), .dma_block(dma_block),
		.global_counter_enable(global_counter_enable));

	txi_cpu_model i_txi_cpu_model (.clk_sys(clk_sys), .rst(rst), .abortable(abortable),
		.ret_req(ret_req), .cpu_no_write(cpu_no_write), .cpu_instr_done(cpu_instr_done),
		.cpu_iret(cpu_iret));

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : step

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h000000, d};
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			bad_count++;
			conclude();
		end
		r = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		step(1);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 8'h00);
	endtask : rd

	// Gap counts edges from the abort pulse to the routine start
	task automatic wait_isr;
		int ab;
		ab = -99;
		gap = -1;
		for (lat = 1; lat < 120 && gap < 0; lat++)
		begin
			@(posedge clk_sys);
			if (cpu_abort === 1'b1)
				ab = lat;
			if (isr_start === 1'b1)
				gap = lat - ab;
		end
		if (gap < 0)
		begin
			bad_count++;
			conclude();
		end
	endtask : wait_isr

	task automatic quiet(input int n);
		int hits;
		hits = 0;
		repeat (n)
		begin
			@(posedge clk_sys);
			if (isr_start !== 1'b0)
				hits++;
		end
		chk(hits, 0);
	endtask : quiet

	task automatic ret;
		ret_req <= 1'b1;
		step(1);
		ret_req <= 1'b0;
		step(3);
	endtask : ret

	task automatic ei;
		cpu_ei <= 1'b1;
		step(1);
		cpu_ei <= 1'b0;
	endtask : ei

	initial
	begin
		{rst, avs_read, avs_write, nmi_pin, wdg_end_of_count, cpu_ei, cpu_di, ret_req} = 8'h80;
		{avs_address, avs_writedata, ext_pin, periph_trig} = '0;
		{bad_count, checked, abortable} = '0;
		step(2);
		rst <= 1'b0;
		step(1);
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk(r, rows[i].e);
		end
		// External channel 0, rising edge, abortable instruction
		abortable <= 1'b1;
		wr(8'hf2, 8'h01);
		wr(8'hf4, 8'h01);
		wr(8'hf5, 8'h00);
		wr(8'hf6, 8'h54);
		ei();
		ext_pin[0] <= 1'b1;
		wait_isr();
		chk({isr_top, isr_vector}, 9'h050);
		chk(gap, 18);
		chk(lat <= 55, 1);
		rd(8'he6);
		chk(r, 8'h87);
		rd(8'hf3);
		chk(r, 8'h00);
		ret();
		rd(8'he6);
		chk(r, 8'h97);
		// Channel 1 falls while masked
		ext_pin[1] <= 1'b1;
		step(8);
		rd(8'hf3);
		chk(r, 8'h00);
		ext_pin[1] <= 1'b0;
		step(8);
		rd(8'hf3);
		chk(r, 8'h02);
		quiet(30);
		// Software pending with every extra of the machine cycle
		wr(8'hfa, 8'h07);
		wr(8'hf3, 8'h01);
		wait_isr();
		chk(gap, 23);
		ret();
		wr(8'hfa, 8'h00);
		// Peripherals on a core that cannot abort; level 7 never served
		abortable <= 1'b0;
		wr(8'hf9, 8'h03);
		ei();
		periph_trig <= 4'h3;
		step(1);
		periph_trig <= 4'h0;
		wait_isr();
		chk(isr_vector, 8'h2a);
		chk(gap > 99, 1);
		ret();
		quiet(30);
		rd(8'hf8);
		chk(r, 8'h02);
		// Top level: maskable first, then locked
		abortable <= 1'b1;
		cpu_di <= 1'b1;
		step(1);
		cpu_di <= 1'b0;
		wr(8'hf6, 8'h5c);
		wr(8'he6, 8'ha7);
		nmi_pin <= 1'b1;
		quiet(30);
		rd(8'he6);
		chk(r, 8'he7);
		wr(8'hf7, 8'h80);
		wait_isr();
		chk({isr_top, top_in_service, dma_block}, 3'h7);
		rd(8'he6);
		chk(r, 8'ha7);
		wr(8'hf7, 8'h00);
		rd(8'hf7);
		chk(r, 8'h80);
		ei();
		wr(8'hf3, 8'h01);
		quiet(30);
		ret();
		wait_isr();
		chk({isr_top, isr_vector}, 9'h050);
		ret();
		// Watchdog as source; the pin no longer counts
		wr(8'hf6, 8'h58);
		nmi_pin <= 1'b0;
		step(8);
		wdg_end_of_count <= 1'b1;
		step(1);
		wdg_end_of_count <= 1'b0;
		wait_isr();
		chk(isr_top, 1);
		chk(lat <= 51, 1);
		ret();
		// Nested mode: level 2 preempts level 5, hold bit kept until return
		wr(8'hf5, 8'h01);
		wr(8'he6, 8'h3d);
		chk(global_counter_enable, 1'b0);
		wr(8'hf3, 8'h01);
		wait_isr();
		rd(8'he6);
		chk(r, 8'h2a);
		rd(8'hf7);
		chk(r, 8'ha0);
		ret();
		rd(8'he6);
		chk(r, 8'h3d);
		rd(8'hf7);
		chk(r, 8'h80);
		// Reset in mid-run is the only way to drop the lock
		rst <= 1'b1;
		step(2);
		rst <= 1'b0;
		step(1);
		chk({top_in_service, global_counter_enable}, 2'h1);
		rd(8'hf7);
		chk(r, 8'h00);
		rd(8'he6);
		chk(r, 8'h87);
		conclude();
	end
endmodule : txi_top_tb_top

// file: design/txi_pkg.sv
// Constants, register map and state codes of the top-level and external interrupt controller.
// Assumes a single clock domain and pins already synchronous to it.
// Overview of operation
// - Pin or watchdog end-of-count feeds top level
// - Top-level pin edge follows edge select bit
// - Selected top-level event sets top-level pending
// - Maskable top-level needs pending, enable, global enable
// - Set-only lock makes top level unmaskable
// - Top-level service blocks every other request
// - Top level leaves enable, level, hold bits alone
// - Acknowledge clears top pending; software may set
// - Peripheral pending set by trigger, software writable
// - Peripheral request needs mask, pending, global enable
// - Three-bit level, zero highest, seven never served
// - Each channel supplies a vector table pointer
// - Sample every five cycles, acknowledge adds one
// - Abort instruction if unwritten, else finish first
// - External response spans twenty-six to fifty-five
// - Unmaskable top response spans twenty-two to fifty-one
// - Machine cycle eighteen, plus two, plus two
// - Wait-for-interrupt mode adds one wake cycle
// - Global enable cleared on maskable entry, set on maskable return
// - Mode bit picks concurrent or nested arbitration
// - External edge polarity per edge select bit
// - External pending set on edge, cleared on acknowledge
// - External mask bit resets to zero, gates request
// - Pair priority upper bits, channel parity lowest
package txi_pkg;
	// Word indices on the bus
	localparam logic [7:0] ADR_CENTRAL = 8'he6;
	localparam logic [7:0] ADR_EDGE = 8'hf2;
	localparam logic [7:0] ADR_PEND = 8'hf3;
	localparam logic [7:0] ADR_MASK = 8'hf4;
	localparam logic [7:0] ADR_PRIO = 8'hf5;
	localparam logic [7:0] ADR_TOPCFG = 8'hf6;
	localparam logic [7:0] ADR_LOCK = 8'hf7;
	localparam logic [7:0] ADR_PPEND = 8'hf8;
	localparam logic [7:0] ADR_PMASK = 8'hf9;
	localparam logic [7:0] ADR_CORE = 8'hfa;
	localparam logic [7:0] ADR_STAT = 8'hfb;
	// Reset values
	localparam logic [7:0] RST_CENTRAL = 8'h87;
	localparam logic [7:0] RST_EDGE = 8'h00;
	localparam logic [7:0] RST_PEND = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_PRIO = 8'hff;
	localparam logic [7:0] RST_TOPCFG = 8'h04;
	localparam logic [7:0] RST_CORE = 8'h00;
	// Field positions
	localparam int B_CNT_EN = 7;
	localparam int B_TLP = 6;
	localparam int B_TLEN = 5;
	localparam int B_GIE = 4;
	localparam int B_MODE = 3;
	localparam int B_TEDGE = 3;
	localparam int B_TSRC = 2;
	localparam int B_LOCK = 7;
	localparam int B_WAIT_MODE = 0;
	localparam int B_CSAVE = 1;
	localparam int B_STKRF = 2;
	localparam logic [2:0] LVL_NONE = 3'h7;
	// Timing in core clock cycles
	localparam int ARB_CYCLES = 5;
	localparam logic [2:0] ARB_LAST = 3'(ARB_CYCLES - 1);
	localparam logic [4:0] MC_BASE = 5'h12;
	localparam logic [4:0] MC_STK = 5'h02;
	localparam logic [4:0] MC_CSEG = 5'h02;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ACK = 3'b001,
		S_WAIT = 3'b010,
		S_WAKE = 3'b011,
		S_MACH = 3'b100
	} txi_state_e;
endpackage : txi_pkg

// file: design/txi_top.sv
// Top-level, external and peripheral interrupt arbitration with its register file.
// Assumes an Avalon-MM master and a core sequencer on clk_sys; pins synchronous.
//
// Register access over Avalon-MM is this design's own decision.
module txi_top #(
	parameter int NP = 4,
	// Arbitrary vector for the top-level channel
	parameter logic [7:0] TOP_VECTOR = 8'h00
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Request sources
	input wire logic nmi_pin,
	input wire logic wdg_end_of_count,
	input wire logic [7:0] ext_pin,
	input wire logic [NP-1:0] periph_trig,
	input wire logic [NP*3-1:0] periph_level,
	input wire logic [NP*7-1:0] periph_vector,
	// Core sequencer
	input wire logic cpu_no_write,
	input wire logic cpu_instr_done,
	input wire logic cpu_iret,
	input wire logic cpu_ei,
	input wire logic cpu_di,
	output logic cpu_abort,
	output logic isr_start,
	output logic [7:0] isr_vector,
	output logic isr_top,
	output logic top_in_service,
	output logic dma_block,
	output logic global_counter_enable
);
	function automatic logic [2:0] ext_level(input logic [7:0] prio, input logic [2:0] ch);
		ext_level = {prio[{ch[2:1], 1'b1}], prio[{ch[2:1], 1'b0}], ch[0]};
	endfunction : ext_level

	function automatic logic [3:0] hold_pop(input logic [6:0] h);
		hold_pop = 4'h0;
		for (int i = 6; i >= 0; i--)
		begin
			if (h[i])
				hold_pop = {1'b1, 3'(i)};
		end
	endfunction : hold_pop

	txi_pkg::txi_state_e state_q;
	logic ack_q;
	logic wr_en;
	logic [7:0] wdat;
	logic [7:0] rd_mux;
	logic [7:0] edge_select_bits_q;
	logic [7:0] channel_pending_bits_q;
	logic [7:0] mask_flag_q;
	logic [7:0] prio_q;
	logic [7:0] topcfg_q;
	logic [7:0] core_q;
	logic [NP-1:0] pending_flag_q;
	logic [NP-1:0] pmask_q;
	logic top_level_pending_q;
	logic top_level_maskable_enable_q;
	logic global_irq_enable_q;
	logic arbitration_mode_select_q;
	logic [2:0] current_priority_level_q;
	logic top_level_unmaskable_lock_q;
	logic [6:0] hold_q;
	logic top_q;
	logic cnt_en_q;
	logic nmi_s_q;
	logic nmi_p_q;
	logic [7:0] ext_s_q;
	logic [7:0] ext_p_q;
	logic [7:0] ext_evt;
	logic nmi_evt;
	logic top_evt;
	logic top_req;
	logic [2:0] arb_q;
	logic sample;
	logic go;
	logic best_hit;
	logic best_ext;
	logic [2:0] best_idx;
	logic [2:0] best_lvl;
	logic [7:0] best_vec;
	logic win_top_q;
	logic win_ext_q;
	logic [2:0] win_idx_q;
	logic [2:0] win_lvl_q;
	logic [7:0] win_vec_q;
	logic [4:0] mc_q;
	logic [4:0] mc_total;
	logic ack_now;
	logic ack_mask;
	logic ret_mask;
	logic [3:0] pop;
	logic [7:0] clr_ext;
	logic [NP-1:0] clr_per;
	logic [4:0] h_len;

	// Two-cycle bus access: read data registered with the wait cycle
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_en = avs_write & ack_q;
	assign wdat = avs_writedata[7:0];

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read | avs_write) & ~ack_q;
	end

	always_comb
	begin
		case (avs_address)
			txi_pkg::ADR_CENTRAL: rd_mux = {cnt_en_q, top_level_pending_q, top_level_maskable_enable_q,
				global_irq_enable_q, arbitration_mode_select_q, current_priority_level_q};
			txi_pkg::ADR_EDGE: rd_mux = edge_select_bits_q;
			txi_pkg::ADR_PEND: rd_mux = channel_pending_bits_q;
			txi_pkg::ADR_MASK: rd_mux = mask_flag_q;
			txi_pkg::ADR_PRIO: rd_mux = prio_q;
			txi_pkg::ADR_TOPCFG: rd_mux = topcfg_q;
			txi_pkg::ADR_LOCK: rd_mux = {top_level_unmaskable_lock_q, hold_q};
			txi_pkg::ADR_PPEND: rd_mux = 8'(pending_flag_q);
			txi_pkg::ADR_PMASK: rd_mux = 8'(pmask_q);
			txi_pkg::ADR_CORE: rd_mux = core_q;
			txi_pkg::ADR_STAT: rd_mux = {top_q, state_q != txi_pkg::S_IDLE, win_ext_q, win_idx_q, win_lvl_q[1:0]};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			avs_readdata <= 32'h0;
		else if (avs_read & ~ack_q)
			avs_readdata <= {24'h0, rd_mux};
	end

	// Plain software configuration
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			edge_select_bits_q <= txi_pkg::RST_EDGE;
			mask_flag_q <= txi_pkg::RST_MASK;
			prio_q <= txi_pkg::RST_PRIO;
			topcfg_q <= txi_pkg::RST_TOPCFG;
			core_q <= txi_pkg::RST_CORE;
			pmask_q <= '0;
		end
		else if (wr_en)
		begin
			if (avs_address == txi_pkg::ADR_EDGE)
				edge_select_bits_q <= wdat;
			if (avs_address == txi_pkg::ADR_MASK)
				mask_flag_q <= wdat;
			if (avs_address == txi_pkg::ADR_PRIO)
				prio_q <= wdat;
			if (avs_address == txi_pkg::ADR_TOPCFG)
				topcfg_q <= wdat;
			if (avs_address == txi_pkg::ADR_CORE)
				core_q <= wdat;
			if (avs_address == txi_pkg::ADR_PMASK)
				pmask_q <= wdat[NP-1:0];
		end
	end

	// Pin sampling; the previous sample is the comparison point
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			nmi_s_q <= 1'b0;
			nmi_p_q <= 1'b0;
			ext_s_q <= 8'h00;
			ext_p_q <= 8'h00;
		end
		else
		begin
			nmi_s_q <= nmi_pin;
			nmi_p_q <= nmi_s_q;
			ext_s_q <= ext_pin;
			ext_p_q <= ext_s_q;
		end
	end

	assign ext_evt = (edge_select_bits_q & ext_s_q & ~ext_p_q)
		| (~edge_select_bits_q & ~ext_s_q & ext_p_q);
	assign nmi_evt = topcfg_q[txi_pkg::B_TEDGE] ? (nmi_s_q & ~nmi_p_q) : (~nmi_s_q & nmi_p_q);
	assign top_evt = topcfg_q[txi_pkg::B_TSRC] ? nmi_evt : wdg_end_of_count;

	assign top_req = top_level_pending_q
		& (top_level_unmaskable_lock_q | (top_level_maskable_enable_q & global_irq_enable_q));

	// Arbitration window
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			arb_q <= 3'h0;
		else if (arb_q == txi_pkg::ARB_LAST)
			arb_q <= 3'h0;
		else
			arb_q <= arb_q + 3'h1;
	end

	assign sample = (arb_q == txi_pkg::ARB_LAST);
	// Nothing is arbitrated while the top-level routine runs
	assign go = sample && (state_q == txi_pkg::S_IDLE) && !top_q;

	// Winner must beat the current level strictly, so level 7 never wins
	always_comb
	begin
		logic [2:0] lvl;
		lvl = 3'h0;
		best_lvl = current_priority_level_q;
		best_hit = 1'b0;
		best_ext = 1'b0;
		best_idx = 3'h0;
		best_vec = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			lvl = ext_level(prio_q, 3'(i));
			if (global_irq_enable_q && channel_pending_bits_q[i] && mask_flag_q[i] && lvl < best_lvl)
			begin
				best_lvl = lvl;
				best_hit = 1'b1;
				best_ext = 1'b1;
				best_idx = 3'(i);
				best_vec = {topcfg_q[7:4], 3'(i), 1'b0};
			end
		end
		for (int j = 0; j < NP; j++)
		begin
			lvl = periph_level[j*3 +: 3];
			if (global_irq_enable_q && pending_flag_q[j] && pmask_q[j] && lvl < best_lvl)
			begin
				best_lvl = lvl;
				best_hit = 1'b1;
				best_ext = 1'b0;
				best_idx = 3'(j);
				best_vec = {1'b0, periph_vector[j*7 +: 7]};
			end
		end
	end

	assign mc_total = txi_pkg::MC_BASE
		+ (core_q[txi_pkg::B_STKRF] ? txi_pkg::MC_STK : 5'h00)
		+ (core_q[txi_pkg::B_CSAVE] ? txi_pkg::MC_CSEG : 5'h00);

	// Response sequence: acknowledge, abort or finish, optional wake, machine cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_q <= txi_pkg::S_IDLE;
			win_top_q <= 1'b0;
			win_ext_q <= 1'b0;
			win_idx_q <= 3'h0;
			win_lvl_q <= txi_pkg::LVL_NONE;
			win_vec_q <= 8'h00;
			mc_q <= 5'h00;
		end
		else
		begin
			unique case (state_q)
				txi_pkg::S_IDLE:
				begin
					if (go && top_req)
					begin
						state_q <= txi_pkg::S_ACK;
						win_top_q <= 1'b1;
						win_vec_q <= TOP_VECTOR;
					end
					else if (go && best_hit)
					begin
						state_q <= txi_pkg::S_ACK;
						win_top_q <= 1'b0;
						win_ext_q <= best_ext;
						win_idx_q <= best_idx;
						win_lvl_q <= best_lvl;
						win_vec_q <= best_vec;
					end
				end
				txi_pkg::S_ACK:
					state_q <= txi_pkg::S_WAIT;
				txi_pkg::S_WAIT:
				begin
					if (cpu_no_write || cpu_instr_done)
					begin
						mc_q <= mc_total - 5'h01;
						state_q <= core_q[txi_pkg::B_WAIT_MODE] ? txi_pkg::S_WAKE : txi_pkg::S_MACH;
					end
				end
				txi_pkg::S_WAKE:
					state_q <= txi_pkg::S_MACH;
				txi_pkg::S_MACH:
				begin
					if (mc_q == 5'h00)
						state_q <= txi_pkg::S_IDLE;
					else
						mc_q <= mc_q - 5'h01;
				end
				default:
					state_q <= txi_pkg::S_IDLE;
			endcase
		end
	end

	// Core handshake outputs
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cpu_abort <= 1'b0;
			isr_start <= 1'b0;
			isr_vector <= 8'h00;
			isr_top <= 1'b0;
		end
		else
		begin
			cpu_abort <= (state_q == txi_pkg::S_WAIT) && cpu_no_write;
			isr_start <= (state_q == txi_pkg::S_MACH) && (mc_q == 5'h00);
			if ((state_q == txi_pkg::S_MACH) && (mc_q == 5'h00))
			begin
				isr_vector <= win_vec_q;
				isr_top <= win_top_q;
			end
		end
	end

	assign ack_now = (state_q == txi_pkg::S_ACK);
	assign ack_mask = ack_now && !win_top_q;
	assign ret_mask = cpu_iret && !top_q;
	assign pop = hold_pop(hold_q);
	assign clr_ext = (ack_mask && win_ext_q) ? (8'h01 << win_idx_q) : 8'h00;
	assign clr_per = (ack_mask && !win_ext_q) ? (NP'(1) << win_idx_q) : '0;

	// Pending bits: a new edge wins over acknowledge or software clear
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			channel_pending_bits_q <= txi_pkg::RST_PEND;
		else if (wr_en && avs_address == txi_pkg::ADR_PEND)
			channel_pending_bits_q <= (wdat & ~clr_ext) | ext_evt;
		else
			channel_pending_bits_q <= (channel_pending_bits_q & ~clr_ext) | ext_evt;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pending_flag_q <= '0;
		else if (wr_en && avs_address == txi_pkg::ADR_PPEND)
			pending_flag_q <= (wdat[NP-1:0] & ~clr_per) | periph_trig;
		else
			pending_flag_q <= (pending_flag_q & ~clr_per) | periph_trig;
	end

	// Central control; core events follow software writes in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cnt_en_q <= txi_pkg::RST_CENTRAL[txi_pkg::B_CNT_EN];
			top_level_pending_q <= txi_pkg::RST_CENTRAL[txi_pkg::B_TLP];
			top_level_maskable_enable_q <= txi_pkg::RST_CENTRAL[txi_pkg::B_TLEN];
			global_irq_enable_q <= txi_pkg::RST_CENTRAL[txi_pkg::B_GIE];
			arbitration_mode_select_q <= txi_pkg::RST_CENTRAL[txi_pkg::B_MODE];
			current_priority_level_q <= txi_pkg::RST_CENTRAL[2:0];
		end
		else
		begin
			if (wr_en && avs_address == txi_pkg::ADR_CENTRAL)
			begin
				cnt_en_q <= wdat[txi_pkg::B_CNT_EN];
				top_level_maskable_enable_q <= wdat[txi_pkg::B_TLEN];
				arbitration_mode_select_q <= wdat[txi_pkg::B_MODE];
				top_level_pending_q <= (wdat[txi_pkg::B_TLP] & ~(ack_now & win_top_q)) | top_evt;
			end
			else
				top_level_pending_q <= (top_level_pending_q & ~(ack_now & win_top_q)) | top_evt;
			if (cpu_di)
				global_irq_enable_q <= 1'b0;
			else if (cpu_ei || ret_mask)
				global_irq_enable_q <= 1'b1;
			else if (ack_mask)
				global_irq_enable_q <= 1'b0;
			else if (wr_en && avs_address == txi_pkg::ADR_CENTRAL)
				global_irq_enable_q <= wdat[txi_pkg::B_GIE];
			if (ack_mask && arbitration_mode_select_q)
				current_priority_level_q <= win_lvl_q;
			else if (ret_mask && arbitration_mode_select_q)
				current_priority_level_q <= pop[3] ? pop[2:0] : txi_pkg::LVL_NONE;
			else if (wr_en && avs_address == txi_pkg::ADR_CENTRAL)
				current_priority_level_q <= wdat[2:0];
		end
	end

	// Nested hold levels and the set-only lock
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hold_q <= 7'h00;
			top_level_unmaskable_lock_q <= 1'b0;
		end
		else
		begin
			if (wr_en && avs_address == txi_pkg::ADR_LOCK && wdat[txi_pkg::B_LOCK])
				top_level_unmaskable_lock_q <= 1'b1;
			if (ack_mask && arbitration_mode_select_q && current_priority_level_q != txi_pkg::LVL_NONE)
				hold_q[current_priority_level_q] <= 1'b1;
			else if (ret_mask && arbitration_mode_select_q && pop[3])
				hold_q[pop[2:0]] <= 1'b0;
		end
	end

	// Top-level service window, entered at acknowledge
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			top_q <= 1'b0;
		else if (ack_now && win_top_q)
			top_q <= 1'b1;
		else if (cpu_iret)
			top_q <= 1'b0;
	end

	assign top_in_service = top_q;
	assign dma_block = top_q;
	assign global_counter_enable = cnt_en_q;

	// Cycles spent in the machine cycle, for checking only
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			h_len <= 5'h00;
		else if (state_q == txi_pkg::S_MACH)
			h_len <= h_len + 5'h01;
		else
			h_len <= 5'h00;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence seq_gap;
		!sample [*4] ##1 sample;
	endsequence

	sequence seq_wake;
		state_q == txi_pkg::S_WAKE ##1 state_q == txi_pkg::S_MACH;
	endsequence

	AST_WDG_SRC: assert property (!topcfg_q[txi_pkg::B_TSRC] && wdg_end_of_count |=> top_level_pending_q)
		else $error("watchdog event did not set top pending");
	AST_NMI_EDGE: assert property (topcfg_q[txi_pkg::B_TSRC] && nmi_evt |=> top_level_pending_q)
		else $error("pin edge did not set top pending");
	AST_TOP_GO: assert property (go && top_req |=> state_q == txi_pkg::S_ACK && win_top_q)
		else $error("top request not acknowledged");
	AST_LOCK_HOLD: assert property (top_level_unmaskable_lock_q |=> top_level_unmaskable_lock_q)
		else $error("unmaskable lock cleared");
	AST_TOP_BLOCK: assert property (top_q |=> state_q != txi_pkg::S_ACK)
		else $error("request acknowledged during top service");
	AST_TOP_KEEP: assert property (ack_now && win_top_q && !wr_en && !cpu_ei && !cpu_di
		|=> $stable(global_irq_enable_q) && $stable(current_priority_level_q) && $stable(hold_q))
		else $error("top level changed enable or level");
	AST_TOP_CLR: assert property (ack_now && win_top_q && !top_evt && !wr_en |=> !top_level_pending_q)
		else $error("top pending not cleared");
	AST_MASK_ACK: assert property (ack_now && !win_top_q |-> $past(global_irq_enable_q))
		else $error("maskable ack without global enable");
	AST_LVL7: assert property (ack_now && !win_top_q |-> win_lvl_q != txi_pkg::LVL_NONE)
		else $error("level seven acknowledged");
	AST_SAMPLE: assert property (sample |=> seq_gap)
		else $error("sampling period wrong");
	AST_WAIT: assert property (state_q == txi_pkg::S_WAIT && !cpu_no_write && !cpu_instr_done
		|=> state_q == txi_pkg::S_WAIT)
		else $error("left wait before instruction end");
	AST_MACH: assert property (state_q == txi_pkg::S_MACH && mc_q == 5'h00 && !wr_en
		|-> h_len == mc_total - 5'h01 ##1 isr_start)
		else $error("machine cycle length wrong");
	AST_WAKE: assert property (state_q == txi_pkg::S_WAIT && core_q[txi_pkg::B_WAIT_MODE]
		&& (cpu_no_write || cpu_instr_done) |=> seq_wake)
		else $error("wake cycle missing");
	AST_DI: assert property (cpu_di |=> !global_irq_enable_q)
		else $error("disable did not clear enable");
	AST_EXT_SET: assert property (ext_evt != 8'h00
		|=> (channel_pending_bits_q & $past(ext_evt)) == $past(ext_evt))
		else $error("external edge lost");
	AST_PAIR: assert property (ack_now && !win_top_q && win_ext_q
		|-> win_lvl_q == ext_level(prio_q, win_idx_q) || $past(wr_en))
		else $error("pair level wrong");
endmodule : txi_top
